// File: hdl/adc_serial_host_port.sv
// What this block does
// R1 - Data phase follows command byte without gap
// R2 - No output drive during write operations
// R3 - Input line ignored during read operations
// R4 - Ready status readable in command register
// R5 - Host clocks mode three, idle high
// R6 - Host may watch ready pin instead
// R7 - Host first writes command 0x10
// R8 - Host then writes setup 0x68
// R9 - Host reads samples via command 0x38
// R10 - Host repeats wait and read loop
// R11 - Every transaction starts with command byte; a deselect does not end a pending write or read phase
// R12 - Ready low on new result, high after
`timescale 1ns/1ps
module adc_serial_host_port (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Serial pins
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        din,
   output      logic        dout,
   output      logic        dout_oe_n,
   output      logic        result_ready_n,
   // Conversion results
   input  wire logic        res_valid,
   input  wire logic [15:0] res_data,
   output      logic        res_ready,
   // Configuration outputs
   output      logic [1:0]  gain,
   output      logic        standby,
   output      logic [7:0]  setup_value,
   output      logic [7:0]  test_value,
   output      logic        setup_wr
);

   serial_port_pkg::port_state_t state_reg;
   stream_if res_bus ();

   logic        sclk_m, sclk_s, sclk_d, cs_m, cs_s, din_m, din_s;
   logic        active, rise, fall;
   logic [4:0]  bit_cnt_reg;
   logic [4:0]  len;
   logic        last;
   logic [7:0]  cmd_next;
   logic        cmd_done, wr_done, rd_done;
   logic [1:0]  sel_reg;
   logic [15:0] sr_in_reg, sr_out_reg, out_reg, read_word;
   logic        out_full_reg, dout_reg, setup_wr_reg;

   res_buffer u_buf (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .in_valid (res_valid),
      .in_data  (res_data),
      .in_ready (res_ready),
      .out_port (res_bus.src)
   );

   // Pins come from the host clock domain
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {sclk_m, sclk_s, sclk_d} <= 3'h7;
         {cs_m, cs_s}             <= 2'h3;
         {din_m, din_s}           <= 2'h0;
      end else begin
         {sclk_m, sclk_s, sclk_d} <= {sclk, sclk_m, sclk_s};
         {cs_m, cs_s}             <= {cs_n, cs_m};
         {din_m, din_s}           <= {din, din_m};
      end
   end

   assign active   = ~cs_s;
   assign rise     = active & sclk_s & ~sclk_d;
   assign fall     = active & ~sclk_s & sclk_d;
   assign cmd_next = {sr_in_reg[6:0], din_s};
   assign len      = (sel_reg == serial_port_pkg::SEL_DATA) ?
                     serial_port_pkg::DATA_BITS : serial_port_pkg::REG_BITS;
   assign last     = (bit_cnt_reg == len - 5'h01);
   assign cmd_done = rise && (state_reg == serial_port_pkg::ST_CMD) &&
                     (bit_cnt_reg == serial_port_pkg::CMD_BITS - 5'h01);
   assign wr_done  = rise && (state_reg == serial_port_pkg::ST_WRITE) && last;
   assign rd_done  = rise && (state_reg == serial_port_pkg::ST_READ) && last;

   // Phase sequencing; a write to the command register stays in command
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg   <= serial_port_pkg::ST_CMD;
         bit_cnt_reg <= 5'h00;
      end else if (!active) begin
         bit_cnt_reg <= 5'h00;
      end else if (cmd_done) begin
         bit_cnt_reg <= 5'h00;
         if (cmd_next[serial_port_pkg::CMD_RW_BIT]) begin
            state_reg <= serial_port_pkg::ST_READ;
         end else if (cmd_next[serial_port_pkg::CMD_SEL_HI:
                               serial_port_pkg::CMD_SEL_LO]
                      != serial_port_pkg::SEL_COMM) begin
            state_reg <= serial_port_pkg::ST_WRITE;   // R1
         end
      end else if (wr_done || rd_done) begin
         bit_cnt_reg <= 5'h00;
         state_reg   <= serial_port_pkg::ST_CMD;      // R11
      end else if (rise) begin
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
   end

   // Input shift register frozen while reading
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sr_in_reg <= serial_port_pkg::WORD_RST;
      end else if (rise && state_reg != serial_port_pkg::ST_READ) begin
         sr_in_reg <= {sr_in_reg[14:0], din_s};       // R3
      end
   end

   // Command byte fields
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sel_reg <= serial_port_pkg::SEL_COMM;
         gain    <= 2'h0;
         standby <= 1'b0;
      end else if (cmd_done) begin
         sel_reg <= cmd_next[serial_port_pkg::CMD_SEL_HI:
                             serial_port_pkg::CMD_SEL_LO];
         gain    <= cmd_next[serial_port_pkg::CMD_GN_HI:0];
         standby <= cmd_next[serial_port_pkg::CMD_SB_BIT];
      end
   end

   // Register writes; data register writes are dropped
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         setup_value  <= serial_port_pkg::SETUP_RST;
         test_value   <= serial_port_pkg::TEST_RST;
         setup_wr_reg <= 1'b0;
      end else begin
         setup_wr_reg <= wr_done && sel_reg == serial_port_pkg::SEL_SETUP;
         if (wr_done && sel_reg == serial_port_pkg::SEL_SETUP)
            setup_value <= cmd_next;                  // R1
         if (wr_done && sel_reg == serial_port_pkg::SEL_TEST)
            test_value <= cmd_next;
      end
   end
   assign setup_wr = setup_wr_reg;

   always_comb begin
      case (cmd_next[serial_port_pkg::CMD_SEL_HI:serial_port_pkg::CMD_SEL_LO])
         serial_port_pkg::SEL_COMM:
            read_word = {result_ready_n, cmd_next[6:0], 8'h00};  // R4
         serial_port_pkg::SEL_SETUP: read_word = {setup_value, 8'h00};
         serial_port_pkg::SEL_TEST:  read_word = {test_value, 8'h00};
         default:                    read_word = out_reg;
      endcase
   end

   // Mode three: output changes on falling edges, MSB on the first one
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sr_out_reg <= serial_port_pkg::WORD_RST;
         dout_reg   <= 1'b1;
      end else if (cmd_done && cmd_next[serial_port_pkg::CMD_RW_BIT]) begin
         sr_out_reg <= read_word;
      end else if (fall && state_reg == serial_port_pkg::ST_READ) begin
         dout_reg   <= sr_out_reg[15];
         sr_out_reg <= {sr_out_reg[14:0], 1'b0};
      end
   end
   assign dout      = dout_reg;
   assign dout_oe_n = ~(active && state_reg == serial_port_pkg::ST_READ); // R2

   // Output word held while full, so it never changes under a read
   assign res_bus.ready = ~out_full_reg;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_reg      <= serial_port_pkg::WORD_RST;
         out_full_reg <= 1'b0;
      end else if (res_bus.valid && !out_full_reg) begin
         out_reg      <= res_bus.data;
         out_full_reg <= 1'b1;                                  // R12
      end else if (rd_done && sel_reg == serial_port_pkg::SEL_DATA) begin
         out_full_reg <= 1'b0;                                  // R12
      end
   end
   assign result_ready_n = ~out_full_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence data_read_end;
      rd_done && sel_reg == serial_port_pkg::SEL_DATA;
   endsequence

   sequence new_result;
      res_bus.valid && !out_full_reg;
   endsequence

   cmd_to_write_a: assert property ( // R1
      cmd_done && !cmd_next[serial_port_pkg::CMD_RW_BIT] &&
      cmd_next[5:4] != serial_port_pkg::SEL_COMM
      |=> state_reg == serial_port_pkg::ST_WRITE && bit_cnt_reg == 5'h00)
      else $error("write phase not entered after command byte");
   no_drive_write_a: assert property ( // R2
      state_reg != serial_port_pkg::ST_READ |-> dout_oe_n)
      else $error("output driven outside a read");
   dout_quiet_a: assert property ( // R2
      state_reg != serial_port_pkg::ST_READ |=> $stable(dout))
      else $error("output changed outside a read");
   din_ignored_a: assert property ( // R3
      state_reg == serial_port_pkg::ST_READ &&
      $past(state_reg) == serial_port_pkg::ST_READ |-> $stable(sr_in_reg))
      else $error("input shifted during a read");
   status_bit_a: assert property ( // R4
      cmd_done && cmd_next[serial_port_pkg::CMD_RW_BIT] &&
      cmd_next[5:4] == serial_port_pkg::SEL_COMM
      |=> sr_out_reg[15] == $past(result_ready_n))
      else $error("status bit not loaded for command read");
   cmd_first_a: assert property ( // R11
      (wr_done || rd_done) |=> state_reg == serial_port_pkg::ST_CMD)
      else $error("transaction did not return to command phase");
   ready_low_a: assert property ( // R12
      new_result |=> !result_ready_n ##1 !result_ready_n)
      else $error("ready not asserted for a new result");
   ready_release_a: assert property ( // R12
      data_read_end |=> result_ready_n)
      else $error("ready not released after data read");
endmodule : adc_serial_host_port

// File: hdl/serial_port_pkg.sv
package serial_port_pkg;

   localparam int         WORD_W     = 16;
   localparam int         REG_W      = 8;
   localparam int         BUF_DEPTH  = 2;

   // Bit counts per transfer phase
   localparam logic [4:0] CMD_BITS   = 5'h08;
   localparam logic [4:0] REG_BITS   = 5'h08;
   localparam logic [4:0] DATA_BITS  = 5'h10;

   // Register select codes
   localparam logic [1:0] SEL_COMM   = 2'h0;
   localparam logic [1:0] SEL_SETUP  = 2'h1;
   localparam logic [1:0] SEL_TEST   = 2'h2;
   localparam logic [1:0] SEL_DATA   = 2'h3;

   // Command byte field positions
   localparam int         CMD_SEL_HI = 5;
   localparam int         CMD_SEL_LO = 4;
   localparam int         CMD_RW_BIT = 3;
   localparam int         CMD_SB_BIT = 2;
   localparam int         CMD_GN_HI  = 1;

   // Reset values
   localparam logic [7:0]  SETUP_RST = 8'h00;
   localparam logic [7:0]  TEST_RST  = 8'h00;
   localparam logic [15:0] WORD_RST  = 16'h0000;

   typedef enum {ST_CMD, ST_WRITE, ST_READ} port_state_t;

endpackage : serial_port_pkg

// File: hdl/stream_if.sv
`timescale 1ns/1ps
interface stream_if;
   logic [15:0] data;
   logic        valid;
   logic        ready;

   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : stream_if

// File: hdl/res_buffer.sv
`timescale 1ns/1ps
module res_buffer (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Filling side
   input  wire logic        in_valid,
   input  wire logic [15:0] in_data,
   output      logic        in_ready,
   // Draining side
   stream_if.src            out_port
);
   logic [15:0] mem_reg [serial_port_pkg::BUF_DEPTH];
   logic        wr_ptr_reg;
   logic        rd_ptr_reg;
   logic [1:0]  count_reg;
   logic        push;
   logic        pop;

   assign in_ready       = (count_reg != 2'(serial_port_pkg::BUF_DEPTH));
   assign out_port.valid = (count_reg != 2'h0);
   assign out_port.data  = mem_reg[rd_ptr_reg];
   assign push           = in_valid & in_ready;
   assign pop            = out_port.valid & out_port.ready;

   genvar i;
   generate
      for (i = 0; i < serial_port_pkg::BUF_DEPTH; i++) begin : g_entry
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               mem_reg[i] <= serial_port_pkg::WORD_RST;
            end else if (push && (wr_ptr_reg == 1'(i))) begin
               mem_reg[i] <= in_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) wr_ptr_reg <= ~wr_ptr_reg;
         if (pop) rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + 2'(push) - 2'(pop);
      end
   end
endmodule : res_buffer

// File: bench/host_link.sv
`timescale 1ns/1ps
module host_link (
   // Clock
   input  wire logic        ref_clk,
   // Serial pins
   output      logic        sclk,
   output      logic        cs_n,
   output      logic        din,
   input  wire logic        dout,
   // Span in which the device may drive
   output      logic        rd_win
);
   initial begin
      sclk   = 1'b1;
      cs_n   = 1'b1;
      din    = 1'b1;
      rd_win = 1'b0;
   end

   // Mode-3 bit: data set on the fall, dout taken just before the rise
   task automatic bit_cyc(input logic b, output logic q);
      @(posedge ref_clk);
      #1 sclk = 1'b0;
      din = b;
      repeat (4) @(posedge ref_clk);
      #1 q = dout;
      sclk = 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask : bit_cyc

   task automatic frame(input logic [7:0] cmd, input logic [15:0] wd,
                        input int nw, input int nr,
                        output logic [15:0] rd);
      logic q;
      rd = 16'h0000;
      @(posedge ref_clk);
      #1 cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) bit_cyc(cmd[i], q);
      rd_win = (nr > 0);
      for (int i = nw - 1; i >= 0; i--) bit_cyc(wd[i], q);
      // Din keeps toggling so an input that is not ignored shows up
      for (int i = 0; i < nr; i++) begin
         bit_cyc(~din, q);
         rd = {rd[14:0], q};
      end
      @(posedge ref_clk);
      #1 cs_n = 1'b1;
      din = ~din;
      repeat (6) @(posedge ref_clk);
      rd_win = 1'b0;
   endtask : frame
endmodule : host_link

// File: bench/tb_adc_serial_host_port.sv
`timescale 1ns/1ps
module tb_adc_serial_host_port;
   logic        ref_clk, rst, sclk, cs_n, din, dout, dout_oe_n;
   logic        result_ready_n, res_valid, res_ready, setup_wr;
   logic        standby, rd_win, dout_line;
   logic [1:0]  gain;
   logic [7:0]  setup_value, test_value, cmd, val;
   logic [15:0] res_data, rd;
   logic [31:0] seed;
   logic [15:0] exp_q[$];
   int          error_cnt, num_checks, wr_cnt;

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Released line floats to its pull-up level, so a late drive shows up
   assign dout_line = dout_oe_n ? 1'b1 : dout;

   host_link host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n),
                   .din(din), .dout(dout_line), .rd_win(rd_win));

   adc_serial_host_port uut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
      .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
      .result_ready_n(result_ready_n), .res_valid(res_valid),
      .res_data(res_data), .res_ready(res_ready), .gain(gain),
      .standby(standby), .setup_value(setup_value),
      .test_value(test_value), .setup_wr(setup_wr));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [7:0] comm_exp(input logic r, input logic [7:0] c);
      return {r, c[6:0]};
   endfunction : comm_exp

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   task automatic push(input logic [15:0] w);
      int i;
      @(posedge ref_clk);
      #1 res_valid = 1'b1;
      res_data = w;
      for (i = 0; i < 200 && res_ready !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      if (i == 200) begin
         check(16'h0000, 16'h0001);
         complete_run;
      end
      @(posedge ref_clk);
      #1 res_valid = 1'b0;
      exp_q.push_back(w);
   endtask : push

   task automatic wait_ready;
      int i;
      for (i = 0; i < 2000 && result_ready_n !== 1'b0; i++) begin
         @(posedge ref_clk);
         #1;
      end
      if (i == 2000) begin
         check(16'h0001, 16'h0000);
         complete_run;
      end
   endtask : wait_ready

   always @(negedge ref_clk) if (setup_wr === 1'b1) wr_cnt++;
   // Outside a read the output must stay released
   always @(negedge ref_clk)
      if (rd_win === 1'b0 && dout_oe_n !== 1'b1)
         check({15'h0000, dout_oe_n}, 16'h0001);

   initial begin
      rst = 1'b1;
      res_valid = 1'b0;
      res_data = 16'h0000;
      error_cnt = 0;
      num_checks = 0;
      wr_cnt = 0;
      seed = 32'h00011a14;
      repeat (6) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 check({setup_value, test_value}, 16'h0000);
      check({11'h000, gain, standby, result_ready_n, dout_oe_n}, 16'h0003);
      host.frame(8'h10, 16'h0068, 8, 0, rd);
      repeat (3) @(posedge ref_clk);
      #1 check({8'h00, setup_value}, 16'h0068);
      check(wr_cnt[15:0], 16'h0001);
      // Command register write stays in the command phase
      host.frame(8'h07, 16'h0000, 0, 0, rd);
      repeat (3) @(posedge ref_clk);
      #1 check({13'h0000, standby, gain}, 16'h0007);
      host.frame(8'h07, 16'h0018, 8, 8, rd);
      check(rd, 16'h0068);
      repeat (4) begin
         seed = lfsr(seed);
         cmd = {4'h2, 1'b0, seed[2:0]};
         val = seed[15:8];
         host.frame(cmd, {8'h00, val}, 8, 0, rd);
         repeat (3) @(posedge ref_clk);
         #1 check({5'h00, test_value, standby, gain}, {5'h00, val, cmd[2:0]});
      end
      // Write phase survives a deselect; data register writes are dropped
      seed = lfsr(seed);
      host.frame(8'h20, 16'h0000, 0, 0, rd);
      host.frame(seed[7:0], 16'h0000, 0, 0, rd);
      host.frame(8'h30, seed[31:16], 16, 0, rd);
      host.frame(8'h28, 16'h0000, 0, 8, rd);
      check(rd, {8'h00, seed[7:0]});
      check({setup_value, test_value}, {8'h68, seed[7:0]});
      // Output word plus both buffer entries, then back-pressure
      repeat (3) begin
         seed = lfsr(seed);
         push(seed[15:0]);
      end
      repeat (3) @(posedge ref_clk);
      #1 check({15'h0000, res_ready}, 16'h0000);
      host.frame(8'h08, 16'h0000, 0, 8, rd);
      check(rd, {8'h00, comm_exp(1'b0, 8'h08)});
      while (exp_q.size() > 0) begin
         wait_ready;
         host.frame(8'h38, 16'h0000, 0, 16, rd);
         check(rd, exp_q.pop_front());
      end
      repeat (6) @(posedge ref_clk);
      #1 check({14'h0000, result_ready_n, res_ready}, 16'h0003);
      complete_run;
   end

   initial begin
      repeat (90000) @(posedge ref_clk);
      check(16'h0000, 16'h0001);
      complete_run;
   end
endmodule : tb_adc_serial_host_port
